/* File: inc/pscl_pkg.sv */
package pscl_pkg;

  // Widths of the strap buses and of the register bus.
  localparam int PHY_ADDR_W = 5;
  localparam int MODE_W = 3;
  localparam int BUS_ADDR_W = 5;
  localparam int BUS_DATA_W = 32;

  // Byte addresses of the registers.
  localparam logic [BUS_ADDR_W-1:0] OFS_CTRL = 5'h00;
  localparam logic [BUS_ADDR_W-1:0] OFS_ADV = 5'h04;
  localparam logic [BUS_ADDR_W-1:0] OFS_STAT = 5'h08;
  localparam logic [BUS_ADDR_W-1:0] OFS_SCR = 5'h0C;

  // Control register field positions.
  localparam int CTRL_LOOPBACK = 14;
  localparam int CTRL_SPEED = 13;
  localparam int CTRL_ANEG = 12;
  localparam int CTRL_PDOWN = 11;
  localparam int CTRL_ISOLATE = 10;
  localparam int CTRL_DUPLEX = 8;
  localparam int CTRL_COLTEST = 7;
  localparam logic [15:0] CTRL_WMASK = 16'h7D80;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // Advertisement register field and its values.
  localparam int ADV_LSB = 5;
  localparam int ADV_W = 4;
  localparam logic [ADV_W-1:0] ADV_NONE = 4'h0;
  localparam logic [ADV_W-1:0] ADV_100HD = 4'h4;
  localparam logic [ADV_W-1:0] ADV_ALL = 4'hF;

  // Status register field positions.
  localparam int STAT_ADDR_LSB = 0;
  localparam int STAT_MODE_LSB = 5;
  localparam int STAT_LOOPBACK = 8;
  localparam int STAT_CRS_TX = 9;
  localparam int STAT_REPEATER = 10;
  localparam int STAT_PDOWN = 11;
  localparam int STAT_LOADED = 12;

  // Mode strap encodings.
  localparam logic [MODE_W-1:0] MODE_10HD = 3'h0;
  localparam logic [MODE_W-1:0] MODE_10FD = 3'h1;
  localparam logic [MODE_W-1:0] MODE_100HD = 3'h2;
  localparam logic [MODE_W-1:0] MODE_100FD = 3'h3;
  localparam logic [MODE_W-1:0] MODE_AN_HD = 3'h4;
  localparam logic [MODE_W-1:0] MODE_REPEAT = 3'h5;
  localparam logic [MODE_W-1:0] MODE_PDOWN = 3'h6;
  localparam logic [MODE_W-1:0] MODE_ALL = 3'h7;

  // Synchroniser depth for pin inputs.
  localparam int SYNC_STAGES = 2;

  // Collision test timing, in bit times of 10 ns, turned into 4 ns cycles.
  localparam int CLK_PERIOD_PS = 4000;
  localparam int BIT_TIME_PS = 10000;
  localparam int COL_ASSERT_BT = 512;
  localparam int COL_RELEASE_BT = 4;
  localparam int COL_ASSERT_CYC = (COL_ASSERT_BT * BIT_TIME_PS) / CLK_PERIOD_PS;
  localparam int COL_RELEASE_CYC = (COL_RELEASE_BT * BIT_TIME_PS) / CLK_PERIOD_PS;

  // Scrambler shift register and the fill placed above the address.
  localparam int SCR_W = 11;
  localparam logic [SCR_W-PHY_ADDR_W-1:0] SCR_FILL = 6'h01;

  // Start-up sequence after hardware reset.
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_LOAD = 2'b01,
    ST_RUN = 2'b10
  } pscl_boot_e;

endpackage

/* File: rtl/pscl_sync.sv */
`timescale 1ns/1ps
module pscl_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;

  // Elaboration check on the width.
  if (WIDTH < 1) begin : g_bad_width
    $error("pscl_sync needs a width of at least one");
  end

  // Two flip-flops; only the second stage reads the first.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule

/* File: rtl/pscl_core.sv */
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module pscl_core #(
  parameter int SYM_W = 5
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic [pscl_pkg::PHY_ADDR_W-1:0] i_phy_address_straps,
  input wire logic [pscl_pkg::MODE_W-1:0] i_mode_straps,
  input wire logic i_tx_en,
  input wire logic [SYM_W-1:0] i_scrambler_out,
  input wire logic [SYM_W-1:0] i_line_rx_symbol,
  input wire logic i_col_detect,
  input wire logic i_scr_advance,
  input wire logic i_mgmt_frame_valid,
  input wire logic [pscl_pkg::PHY_ADDR_W-1:0] i_mgmt_frame_addr,
  input wire logic [pscl_pkg::BUS_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [pscl_pkg::BUS_DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [pscl_pkg::BUS_DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic [SYM_W-1:0] o_descrambler_in,
  output logic [SYM_W-1:0] o_line_tx_symbol,
  output logic o_tx_drivers_on,
  output logic o_col,
  output logic o_loopback_active,
  output logic o_power_down,
  output logic o_crs_during_tx,
  output logic o_repeater_mode,
  output logic o_mgmt_respond,
  output logic o_scrambler_key
);

  localparam int COL_RISE_BOUND = 4;
  localparam int COL_FALL_BOUND = 10;

  // Elaboration checks.
  if (SYM_W < 1) begin : g_bad_sym
    $error("pscl_core needs a symbol width of at least one");
  end
  if (pscl_pkg::COL_RELEASE_CYC < 3) begin : g_bad_timing
    $error("pscl_core cannot release collision inside the allowed time");
  end

  // Default control bits 13,12,8 plus power-down, chosen by the mode straps.
  function automatic logic [15:0] mode_ctrl(input logic [pscl_pkg::MODE_W-1:0] mode);
    logic [15:0] v;
    v = pscl_pkg::CTRL_RESET;
    case (mode)
      pscl_pkg::MODE_10HD: v = pscl_pkg::CTRL_RESET;
      pscl_pkg::MODE_10FD: v[pscl_pkg::CTRL_DUPLEX] = 1'b1;
      pscl_pkg::MODE_100HD: v[pscl_pkg::CTRL_SPEED] = 1'b1;
      pscl_pkg::MODE_100FD: begin
        v[pscl_pkg::CTRL_SPEED] = 1'b1;
        v[pscl_pkg::CTRL_DUPLEX] = 1'b1;
      end
      pscl_pkg::MODE_AN_HD, pscl_pkg::MODE_REPEAT: begin
        v[pscl_pkg::CTRL_SPEED] = 1'b1;
        v[pscl_pkg::CTRL_ANEG] = 1'b1;
      end
      pscl_pkg::MODE_PDOWN: v[pscl_pkg::CTRL_PDOWN] = 1'b1;
      pscl_pkg::MODE_ALL: begin
        v[pscl_pkg::CTRL_SPEED] = 1'b1;
        v[pscl_pkg::CTRL_ANEG] = 1'b1;
        v[pscl_pkg::CTRL_DUPLEX] = 1'b1;
      end
      default: v = pscl_pkg::CTRL_RESET;
    endcase
    return v;
  endfunction

  // Default advertisement field for a mode.
  function automatic logic [pscl_pkg::ADV_W-1:0] mode_adv(
    input logic [pscl_pkg::MODE_W-1:0] mode);
    case (mode)
      pscl_pkg::MODE_AN_HD, pscl_pkg::MODE_REPEAT: return pscl_pkg::ADV_100HD;
      pscl_pkg::MODE_ALL: return pscl_pkg::ADV_ALL;
      default: return pscl_pkg::ADV_NONE;
    endcase
  endfunction

  // Whether carrier sense covers transmit as well as receive for a mode.
  function automatic logic mode_crs_tx(input logic [pscl_pkg::MODE_W-1:0] mode);
    case (mode)
      pscl_pkg::MODE_10HD, pscl_pkg::MODE_100HD, pscl_pkg::MODE_AN_HD: return 1'b1;
      pscl_pkg::MODE_ALL: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Merge write data into a register under the byte enables and a write mask.
  function automatic logic [15:0] merge_be(input logic [15:0] old, input logic [15:0] wr,
                                           input logic [1:0] be, input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = {{8{be[1]}}, {8{be[0]}}} & mask;
    return (old & ~lanes) | (wr & lanes);
  endfunction

  logic [pscl_pkg::PHY_ADDR_W-1:0] addr_sync;
  logic [pscl_pkg::MODE_W-1:0] mode_sync;
  logic tx_en_s;
  logic tx_en_d;
  pscl_pkg::pscl_boot_e boot;
  pscl_pkg::pscl_boot_e next_boot;
  logic [1:0] boot_cnt;
  logic [pscl_pkg::PHY_ADDR_W-1:0] phy_addr;
  logic [pscl_pkg::MODE_W-1:0] mode;
  logic [15:0] ctrl;
  logic [pscl_pkg::ADV_W-1:0] adv;
  logic [pscl_pkg::SCR_W-1:0] lfsr;
  logic load_now;
  logic bus_req;
  logic bus_done;
  logic loopback;
  logic coltest;
  logic [pscl_pkg::BUS_DATA_W-1:0] next_readdata;

  // Pin inputs: straps and transmit enable pass two flip-flops.
  pscl_sync #(
    .WIDTH(pscl_pkg::PHY_ADDR_W + pscl_pkg::MODE_W + 1)
  ) u_sync (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_async({i_phy_address_straps, i_mode_straps, i_tx_en}),
    .o_sync({addr_sync, mode_sync, tx_en_s})
  );

  assign load_now = (boot == pscl_pkg::ST_LOAD);
  assign bus_req = i_avs_read | i_avs_write;
  assign bus_done = bus_req & ~o_avs_waitrequest;
  assign loopback = ctrl[pscl_pkg::CTRL_LOOPBACK];
  assign coltest = ctrl[pscl_pkg::CTRL_COLTEST];

  // Start-up: wait for the strap synchroniser to fill, load once, then run.
  always_comb begin
    next_boot = boot;
    case (boot)
      pscl_pkg::ST_HOLD: begin
        if (boot_cnt == 2'(pscl_pkg::SYNC_STAGES)) begin
          next_boot = pscl_pkg::ST_LOAD;
        end
      end
      pscl_pkg::ST_LOAD: next_boot = pscl_pkg::ST_RUN;
      pscl_pkg::ST_RUN: next_boot = pscl_pkg::ST_RUN;
      default: next_boot = pscl_pkg::ST_HOLD;
    endcase
  end

  // Start-up state and its settling counter.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      boot <= pscl_pkg::ST_HOLD;
      boot_cnt <= 2'h0;
    end else begin
      boot <= next_boot;
      if (boot == pscl_pkg::ST_HOLD) begin
        boot_cnt <= boot_cnt + 2'h1;
      end
    end
  end

  // Straps are caught once after reset release and held until the next reset.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      phy_addr <= '0;
      mode <= '0;
    end else if (load_now) begin
      phy_addr <= addr_sync;
      mode <= mode_sync;
    end
  end

  // Control register: strap defaults at load, software writes afterwards.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl <= pscl_pkg::CTRL_RESET;
    end else if (load_now) begin
      ctrl <= mode_ctrl(mode_sync);
    end else if (bus_done && i_avs_write && i_avs_address == pscl_pkg::OFS_CTRL) begin
      ctrl <= merge_be(ctrl, i_avs_writedata[15:0], i_avs_byteenable[1:0],
                       pscl_pkg::CTRL_WMASK);
    end
  end

  // Advertisement register, bits 8 to 5.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      adv <= pscl_pkg::ADV_NONE;
    end else if (load_now) begin
      adv <= mode_adv(mode_sync);
    end else if (bus_done && i_avs_write && i_avs_address == pscl_pkg::OFS_ADV &&
                 i_avs_byteenable[0] && i_avs_byteenable[1]) begin
      adv <= i_avs_writedata[pscl_pkg::ADV_LSB +: pscl_pkg::ADV_W];
    end
  end

  // Scrambler key stream, seeded from the captured address.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lfsr <= {pscl_pkg::SCR_FILL, {pscl_pkg::PHY_ADDR_W{1'b0}}};
      o_scrambler_key <= 1'b0;
    end else if (load_now) begin
      lfsr <= {pscl_pkg::SCR_FILL, addr_sync};
      o_scrambler_key <= 1'b0;
    end else if (i_scr_advance && boot == pscl_pkg::ST_RUN) begin
      lfsr <= {lfsr[pscl_pkg::SCR_W-2:0], lfsr[10] ^ lfsr[8]};
      o_scrambler_key <= lfsr[10] ^ lfsr[8];
    end
  end

  // Read data for the addressed register; unmapped addresses read zero.
  always_comb begin
    next_readdata = 32'h0000_0000;
    case (i_avs_address)
      pscl_pkg::OFS_CTRL: next_readdata[15:0] = ctrl;
      pscl_pkg::OFS_ADV: next_readdata[pscl_pkg::ADV_LSB +: pscl_pkg::ADV_W] = adv;
      pscl_pkg::OFS_STAT: begin
        next_readdata[pscl_pkg::STAT_ADDR_LSB +: pscl_pkg::PHY_ADDR_W] = phy_addr;
        next_readdata[pscl_pkg::STAT_MODE_LSB +: pscl_pkg::MODE_W] = mode;
        next_readdata[pscl_pkg::STAT_LOOPBACK] = o_loopback_active;
        next_readdata[pscl_pkg::STAT_CRS_TX] = o_crs_during_tx;
        next_readdata[pscl_pkg::STAT_REPEATER] = o_repeater_mode;
        next_readdata[pscl_pkg::STAT_PDOWN] = o_power_down;
        next_readdata[pscl_pkg::STAT_LOADED] = (boot == pscl_pkg::ST_RUN);
      end
      pscl_pkg::OFS_SCR: next_readdata[pscl_pkg::SCR_W-1:0] = lfsr;
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  // Bus answer: waitrequest drops for one cycle one edge after a request is seen.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
    end else if (bus_req && o_avs_waitrequest && boot == pscl_pkg::ST_RUN) begin
      o_avs_waitrequest <= 1'b0;
      o_avs_readdata <= next_readdata;
    end else begin
      o_avs_waitrequest <= 1'b1;
    end
  end

  // Mode indications derived from the control register and the latched mode.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_loopback_active <= 1'b0;
      o_power_down <= 1'b0;
      o_crs_during_tx <= 1'b0;
      o_repeater_mode <= 1'b0;
    end else begin
      o_loopback_active <= loopback;
      o_power_down <= ctrl[pscl_pkg::CTRL_PDOWN];
      o_crs_during_tx <= mode_crs_tx(mode);
      o_repeater_mode <= (mode == pscl_pkg::MODE_REPEAT);
    end
  end

  // Receive and line paths; in loopback the line stays silent while sending.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_descrambler_in <= '0;
      o_line_tx_symbol <= '0;
      o_tx_drivers_on <= 1'b0;
    end else begin
      o_descrambler_in <= loopback ? i_scrambler_out : i_line_rx_symbol;
      if (loopback && tx_en_s) begin
        o_line_tx_symbol <= '0;
        o_tx_drivers_on <= 1'b0;
      end else begin
        o_line_tx_symbol <= i_scrambler_out;
        o_tx_drivers_on <= ~ctrl[pscl_pkg::CTRL_PDOWN];
      end
    end
  end

  // Collision output: test mode follows transmit enable, otherwise loopback forces it low.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_en_d <= 1'b0;
      o_col <= 1'b0;
    end else begin
      tx_en_d <= tx_en_s;
      if (coltest) begin
        o_col <= tx_en_s;
      end else if (loopback) begin
        o_col <= 1'b0;
      end else begin
        o_col <= i_col_detect;
      end
    end
  end

  // Management frames are answered only for the captured address.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_mgmt_respond <= 1'b0;
    end else begin
      o_mgmt_respond <= i_mgmt_frame_valid && (boot == pscl_pkg::ST_RUN) &&
                        (i_mgmt_frame_addr == phy_addr);
    end
  end

  // Steps of a collision test transmission.
  sequence s_test_tx_rise;
    coltest && tx_en_s && !tx_en_d;
  endsequence
  sequence s_test_tx_fall;
    coltest && !tx_en_s && tx_en_d;
  endsequence

  AST_LOOPBACK_ENTRY: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    loopback |=> o_loopback_active)
    else $error("Loopback bit set but loopback not active.");
  AST_LOOP_PATH: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    loopback |=> o_descrambler_in == $past(i_scrambler_out))
    else $error("Descrambler input does not follow scrambler output in loopback.");
  AST_COL_QUIET: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (loopback && !coltest) |=> !o_col)
    else $error("Collision active in loopback without collision test.");
  AST_TX_SILENT: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (loopback && tx_en_s) |=> (!o_tx_drivers_on && o_line_tx_symbol == '0))
    else $error("Line driven during loopback transmission.");
  AST_ADDR_HELD: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (boot == pscl_pkg::ST_RUN) |=> $stable(phy_addr))
    else $error("Captured address changed after start-up.");
  AST_MGMT_MATCH: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    o_mgmt_respond |-> ($past(i_mgmt_frame_addr) == phy_addr && $past(i_mgmt_frame_valid)))
    else $error("Management response to a frame for another address.");
  AST_SEED: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    load_now |=> lfsr == {pscl_pkg::SCR_FILL, phy_addr})
    else $error("Scrambler not seeded from the captured address.");
  AST_PDOWN_MODE: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (load_now && mode_sync == pscl_pkg::MODE_PDOWN) |-> ##2 o_power_down)
    else $error("Power-down mode strap did not power the device down.");
  AST_ALL_MODE: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (load_now && mode_sync == pscl_pkg::MODE_ALL) |=>
      (ctrl[pscl_pkg::CTRL_ANEG] && !ctrl[pscl_pkg::CTRL_ISOLATE] && adv == pscl_pkg::ADV_ALL))
    else $error("All-capable mode defaults wrong.");
  AST_COL_RISE: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    s_test_tx_rise ##1 coltest |-> ##[0:COL_RISE_BOUND] o_col)
    else $error("Collision test did not assert collision in time.");
  AST_COL_FALL: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    s_test_tx_fall ##1 coltest |-> ##[0:COL_FALL_BOUND] !o_col)
    else $error("Collision test did not release collision in time.");

endmodule

/* File: sim/pscl_mac_model.sv */
`timescale 1ns/1ps
module pscl_mac_model (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_tx_req,
  input wire logic i_col_req,
  output logic o_tx_en,
  output logic o_col_detect,
  output logic [4:0] o_scr_sym,
  output logic [4:0] o_rx_sym
);
  // Symbol streams step every cycle, so a stale copy can never pass for a fresh one.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_tx_en <= 1'b0;
      o_col_detect <= 1'b0;
      o_scr_sym <= 5'h01;
      o_rx_sym <= 5'h1A;
    end else begin
      o_tx_en <= i_tx_req; // Transmit enable is a level held for the whole frame.
      o_col_detect <= i_col_req;
      o_scr_sym <= o_scr_sym + 5'h03;
      o_rx_sym <= o_rx_sym - 5'h05;
    end
  end
endmodule

/* File: sim/phy_strap_config_and_loopback_bench.sv */
`timescale 1ns/1ps
module phy_strap_config_and_loopback_bench;
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic [4:0] straps = 5'h00;
  logic [2:0] mode = 3'h0;
  logic tx_req = 1'b0;
  logic col_req = 1'b0;
  logic scr_adv = 1'b0;
  logic mg_v = 1'b0;
  logic [4:0] mg_a = 5'h00;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0000_0000;
  logic [3:0] be = 4'hF;
  logic [31:0] q, o_rd;
  logic [4:0] sa, scr_sym, rx_sym, dsc_in, line_tx;
  logic tx_en, col_det, wreq, drv_on, col, lb, pd, crs, rep, mresp, key;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed = 57509;
  int m_ctrl, m_adv, m_scr, m_key;
  int ctl_t[8] = '{16'h0000, 16'h0100, 16'h2000, 16'h2100, 16'h3000, 16'h3000, 16'h0800, 16'h3100};
  int adv_t[8] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h4, 4'h4, 4'h0, 4'hF};
  int crs_t[8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};

  pscl_mac_model pscl_mac_model_i (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_tx_req(tx_req),
    .i_col_req(col_req), .o_tx_en(tx_en), .o_col_detect(col_det), .o_scr_sym(scr_sym),
    .o_rx_sym(rx_sym));

  pscl_core pscl_core_i (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_phy_address_straps(straps),
    .i_mode_straps(mode), .i_tx_en(tx_en), .i_scrambler_out(scr_sym),
    .i_line_rx_symbol(rx_sym), .i_col_detect(col_det), .i_scr_advance(scr_adv),
    .i_mgmt_frame_valid(mg_v), .i_mgmt_frame_addr(mg_a), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
    .o_avs_readdata(o_rd), .o_avs_waitrequest(wreq), .o_descrambler_in(dsc_in),
    .o_line_tx_symbol(line_tx), .o_tx_drivers_on(drv_on), .o_col(col),
    .o_loopback_active(lb), .o_power_down(pd), .o_crs_during_tx(crs),
    .o_repeater_mode(rep), .o_mgmt_respond(mresp), .o_scrambler_key(key));

  // Free-running 250 MHz clock.
  always #2 i_clock = ~i_clock;

  // A hung run is cut short and counted as a mismatch.
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One bus cycle held until waitrequest is seen low at a rising edge.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] b, output logic [31:0] r);
    @(posedge i_clock);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    be <= b;
    @(posedge i_clock);
    // Only the bench timeout ends a wait that never sees waitrequest low.
    while (wreq !== 1'b0) begin
      @(posedge i_clock);
    end
    r = o_rd;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  function automatic logic [31:0] stat(input int m, input int a, input int l, input int p);
    return a | (m << 5) | (l << 8) | (crs_t[m] << 9) | ((m == 5) << 10) | (p << 11) | 32'h0000_1000;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  // Straps are set up inside reset and held well past the load.
  task automatic do_reset(input logic [2:0] m, input logic [4:0] a);
    @(posedge i_clock);
    i_rst_b <= 1'b0;
    mode <= m;
    straps <= a;
    tick(8);
    check("wait_in_reset", wreq, 1'b1);
    check("col_in_reset", col, 1'b0);
    @(posedge i_clock);
    i_rst_b <= 1'b1;
    repeat (6) @(posedge i_clock);
    m_ctrl = ctl_t[m];
    m_adv = adv_t[m];
  endtask

  task automatic mgmt(input logic [4:0] a, input logic exp);
    @(posedge i_clock);
    mg_v <= 1'b1;
    mg_a <= a;
    @(posedge i_clock);
    mg_v <= 1'b0;
    #1 check("mgmt_respond", mresp, exp);
  endtask

  // The descrambler input must follow the chosen source one cycle later.
  task automatic watch(input logic l);
    logic [4:0] s, r;
    repeat (4) begin
      @(posedge i_clock);
      s = scr_sym;
      r = rx_sym;
      #1 check("descrambler_in", dsc_in, l ? s : r);
      check("line_tx_pass", line_tx, s);
    end
  endtask

  // Main sequence: every mode, then loopback, collision test and register edges.
  initial begin
    for (int m = 0; m < 8; m++) begin
      sa = 5'($random(seed));
      do_reset(3'(m), sa);
      straps <= ~sa;
      bus(1'b0, pscl_pkg::OFS_CTRL, 32'h0, 4'hF, q);
      check("ctrl_default", q, m_ctrl);
      bus(1'b0, pscl_pkg::OFS_ADV, 32'h0, 4'hF, q);
      check("adv_default", q, m_adv << 5);
      bus(1'b0, pscl_pkg::OFS_STAT, 32'h0, 4'hF, q);
      check("status", q, stat(m, sa, 0, m == 6));
      check("power_down", pd, m == 6);
      check("crs_tx", crs, crs_t[m]);
      check("repeater", rep, m == 5);
      bus(1'b0, pscl_pkg::OFS_SCR, 32'h0, 4'hF, q);
      check("seed", q, 32'h0000_0020 | sa);
      mgmt(sa, 1'b1);
      mgmt(sa ^ 5'h01, 1'b0);
    end
    do_reset(3'h3, 5'h0A);
    bus(1'b1, pscl_pkg::OFS_CTRL, m_ctrl | 32'h0000_4000, 4'hF, q);
    tick(1);
    check("loopback", lb, 1'b1);
    watch(1'b1);
    @(posedge i_clock);
    tx_req <= 1'b1;
    col_req <= 1'b1;
    tick(6);
    check("line_tx", line_tx, 5'h00);
    check("drivers_on", drv_on, 1'b0);
    check("col_lb", col, 1'b0);
    bus(1'b1, pscl_pkg::OFS_CTRL, m_ctrl | 32'h0000_4080, 4'hF, q);
    tick(2);
    check("col_test_on", col, 1'b1);
    @(posedge i_clock);
    tx_req <= 1'b0;
    tick(8);
    check("col_release", col, 1'b0);
    @(posedge i_clock);
    tx_req <= 1'b1;
    tick(8);
    check("col_assert", col, 1'b1);
    bus(1'b1, pscl_pkg::OFS_CTRL, m_ctrl, 4'hF, q);
    tick(6);
    check("loopback_off", lb, 1'b0);
    check("drivers_back", drv_on, 1'b1);
    check("col_normal", col, 1'b1);
    watch(1'b0);
    @(posedge i_clock);
    tx_req <= 1'b0;
    col_req <= 1'b0;
    scr_adv <= 1'b1;
    m_scr = 32'h0000_0020 | 5'h0A;
    // Key bits follow an x^11+x^9 register seeded with the fill and the address.
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clock);
      if (k == 3) begin
        scr_adv <= 1'b0;
      end
      m_key = ((m_scr >> 10) ^ (m_scr >> 8)) & 1;
      m_scr = ((m_scr << 1) | m_key) & 32'h0000_07FF;
      #1 check("scr_key", key, m_key);
    end
    bus(1'b0, pscl_pkg::OFS_SCR, 32'h0, 4'hF, q);
    check("scr_state", q, m_scr);
    bus(1'b1, pscl_pkg::OFS_ADV, 32'h0000_01E0, 4'h1, q);
    bus(1'b0, pscl_pkg::OFS_ADV, 32'h0, 4'hF, q);
    check("adv_partial", q, m_adv << 5);
    bus(1'b1, pscl_pkg::OFS_ADV, 32'h0000_01E0, 4'hF, q);
    bus(1'b0, pscl_pkg::OFS_ADV, 32'h0, 4'hF, q);
    check("adv_write", q, 32'h0000_01E0);
    bus(1'b1, pscl_pkg::OFS_CTRL, 32'hFFFF_FFFF, 4'hF, q);
    bus(1'b0, pscl_pkg::OFS_CTRL, 32'h0, 4'hF, q);
    check("ctrl_mask", q, 32'h0000_7D80);
    bus(1'b1, pscl_pkg::OFS_STAT, 32'hFFFF_FFFF, 4'hF, q);
    bus(1'b0, pscl_pkg::OFS_STAT, 32'h0, 4'hF, q);
    check("status_ro", q, stat(3, 10, 1, 1));
    bus(1'b1, 5'h10, 32'hFFFF_FFFF, 4'hF, q);
    bus(1'b0, 5'h10, 32'h0, 4'hF, q);
    check("unmapped", q, 32'h0000_0000);
    end_of_test();
  end
endmodule
